// file: scu_pkg.sv
// Shared constants and types of the system control register bank
package scu_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_BOOT = 12'h000;
	localparam logic [11:0] OFF_RST = 12'h004;
	localparam logic [11:0] OFF_PWR = 12'h008;
	localparam logic [11:0] OFF_CLK = 12'h00C;
	localparam logic [11:0] OFF_PIN = 12'h014;
	localparam logic [11:0] OFF_DBG = 12'h01C;
	localparam logic [11:0] OFF_RISE = 12'h020;
	localparam logic [11:0] OFF_FALL = 12'h024;
	localparam logic [11:0] OFF_PEND = 12'h028;
	localparam logic [11:0] OFF_PDIV = 12'h038;
	localparam logic [11:0] OFF_SRST = 12'h040;
	localparam logic [11:0] OFF_FRST = 12'h050;
	localparam logic [11:0] OFF_SGATE = 12'h060;
	localparam logic [11:0] OFF_FGATE = 12'h070;
	localparam logic [11:0] OFF_HALT = 12'h080;
	localparam logic [11:0] OFF_ID = 12'h100;
	// Reset cause flags: index within the seven-bit field
	localparam int CAUSE_N = 7;
	localparam int CAUSE_LSB = 25;
	localparam int C_EXT = 0;
	localparam int C_PIN = 1;
	localparam int C_POR = 2;
	localparam int C_SFT = 3;
	localparam int C_INDEPENDENT_WATCHDOG = 4;
	localparam int C_WDOG = 5;
	localparam int C_LPWR = 6;
	localparam int RST_CLR_BIT = 24;
	localparam int RST_EXT_BIT = 1;
	localparam int SOFTWARE_RESET_TRIGGER_BIT = 0;
	// Low-power field codes
	localparam logic [1:0] LP_SLEEP = 2'h0;
	localparam logic [1:0] LP_STOP = 2'h1;
	localparam logic [1:0] LP_STANDBY = 2'h3;
	// Clock source and debug control fields
	localparam int FDIV_HI = 12;
	localparam int FDIV_LO = 8;
	localparam int PLL_RDY = 6;
	localparam int PLL_ON = 5;
	localparam int OSC_RDY = 4;
	localparam int OSC_BYP = 3;
	localparam int OSC_ON = 2;
	localparam int DBG_RTC = 4;
	localparam int DBG_INDEPENDENT_WATCHDOG = 3;
	// Widths
	localparam int PIN_N = 5;
	localparam int IRQ_N = 8;
	localparam int WAKE_N = 9;
	localparam int SLOW_N = 29;
	localparam int FAST_N = 4;
	// Watchdog, timers, general timers and CAN may halt in debug
	localparam logic [28:0] HALT_MASK = 29'h041FC002;
	// Reset values and timing
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [6:0] CAUSE_RESET = 7'h04;
	localparam logic [2:0] BOOT_EDGE = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		PS_RUN = 4'h1,
		PS_SLEEP = 4'h2,
		PS_STOP = 4'h4,
		PS_STANDBY = 4'h8
	} scu_pwr_e;
endpackage

// file: scu_rate_div.sv
// Programmable rate divider giving a one-cycle enable pulse
`timescale 1ns/1ps
module scu_rate_div
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] divide,
	output logic tick
);
	logic [3:0] count;
	logic [3:0] next_count;

	// Counts 0..divide; a shrunk divide wraps at once
	always_comb
	begin
		next_count = (count >= divide) ? 4'h0 : count + 4'h1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= 4'h0;
		else
			count <= next_count;
	end

	assign tick = (count >= divide);
endmodule

// file: scu_system_control.sv
// System control register bank on an AXI4-Lite slave
`timescale 1ns/1ps
module scu_system_control
#(
	// Arbitrary identification value
	parameter logic [31:0] CHIP_ID = 32'h1234_5678
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bootPinZero,
	input wire logic bootPinOne,
	input wire logic extLogicResetReq,
	input wire logic lowpowerResetEvt,
	input wire logic sysWatchdogResetEvt,
	input wire logic indepWatchdogResetEvt,
	input wire logic pinResetEvt,
	input wire logic wfiReq,
	input wire logic irqWake,
	input wire logic debugActive,
	input wire logic [7:0] externalIrqLines,
	input wire logic rtcAlarm,
	input wire logic pllLocked,
	input wire logic extOscStable,
	output logic sysResetReq,
	output logic [1:0] lowPowerSelect,
	output logic sleepActive,
	output logic stopActive,
	output logic standbyActive,
	output logic wakeUp,
	output logic pllOn,
	output logic extOscPower,
	output logic extOscBypass,
	output logic flashClkTick,
	output logic pbusClkTick,
	output logic [4:0] debugPinReuse,
	output logic rtcHaltInDebug,
	output logic indepWatchdogHaltInDebug,
	output logic [28:0] slowBusReset,
	output logic [3:0] fastBusReset,
	output logic [28:0] slowBusClkEn,
	output logic [3:0] fastBusClkEn
);
	// Synchroniser lanes
	localparam int SY_EXT = 0;
	localparam int SY_B0 = 1;
	localparam int SY_B1 = 2;
	localparam int SY_IRQ = 3;
	localparam int SY_ALM = 11;
	localparam int SY_PLL = 12;
	localparam int SY_OSC = 13;
	localparam int SY_N = 14;

	logic [SY_N-1:0] s1, s2, s3, flt, fltD;
	logic [2:0] bootCnt, next_bootCnt;
	logic bootDone, next_bootDone;
	logic [1:0] bootStatus, next_bootStatus;
	logic [6:0] causeFlags, next_causeFlags;
	logic extAllow, next_extAllow;
	logic [1:0] lpSel, next_lpSel;
	logic [7:0] fdiv, next_fdiv;
	logic [2:0] oscCtl, next_oscCtl;
	logic [4:0] pinReuse, next_pinReuse;
	logic [1:0] dbgCtl, next_dbgCtl;
	logic [8:0] riseSel, next_riseSel, fallSel, next_fallSel;
	logic [8:0] pending, next_pending;
	logic [3:0] pbusDiv, next_pbusDiv;
	logic [28:0] slowRst, next_slowRst, slowGate, next_slowGate;
	logic [28:0] clkHalt, next_clkHalt;
	logic [3:0] fastRst, next_fastRst, fastGate, next_fastGate;
	logic next_sysResetReq, next_wakeUp;
	scu_pkg::scu_pwr_e pwrState, next_pwrState;
	logic awHeld, next_awHeld, wHeld, next_wHeld;
	logic [11:0] awAddr, next_awAddr;
	logic [31:0] wData, next_wData, next_rdata;
	logic [3:0] wStrb, next_wStrb;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic wrFire, swTrig, clrTrig, extTrig;
	logic [31:0] wMask, merged;
	logic [8:0] wakeHit;

	// True for every mapped offset
	function automatic logic mapped(input logic [11:0] a);
		case (a)
			scu_pkg::OFF_BOOT, scu_pkg::OFF_RST, scu_pkg::OFF_PWR, scu_pkg::OFF_CLK,
			scu_pkg::OFF_PIN, scu_pkg::OFF_DBG, scu_pkg::OFF_RISE, scu_pkg::OFF_FALL,
			scu_pkg::OFF_PEND, scu_pkg::OFF_PDIV, scu_pkg::OFF_SRST, scu_pkg::OFF_FRST,
			scu_pkg::OFF_SGATE, scu_pkg::OFF_FGATE, scu_pkg::OFF_HALT,
			scu_pkg::OFF_ID: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Read view; pulse bits always read zero
	function automatic logic [31:0] readWord(input logic [11:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			scu_pkg::OFF_BOOT: v[1:0] = bootStatus;
			scu_pkg::OFF_RST:
			begin
				v[scu_pkg::CAUSE_LSB +: scu_pkg::CAUSE_N] = causeFlags;
				v[scu_pkg::RST_EXT_BIT] = extAllow;
			end
			scu_pkg::OFF_PWR: v[1:0] = lpSel;
			scu_pkg::OFF_CLK:
			begin
				v[scu_pkg::FDIV_LO +: 8] = fdiv;
				v[scu_pkg::PLL_RDY] = flt[SY_PLL];
				v[scu_pkg::OSC_RDY] = flt[SY_OSC];
				v[scu_pkg::PLL_ON] = oscCtl[2];
				v[scu_pkg::OSC_BYP] = oscCtl[1];
				v[scu_pkg::OSC_ON] = oscCtl[0];
			end
			scu_pkg::OFF_PIN: v[4:0] = pinReuse;
			scu_pkg::OFF_DBG: v[scu_pkg::DBG_INDEPENDENT_WATCHDOG +: 2] = dbgCtl;
			scu_pkg::OFF_RISE: v[8:0] = riseSel;
			scu_pkg::OFF_FALL: v[8:0] = fallSel;
			scu_pkg::OFF_PEND: v[8:0] = pending;
			scu_pkg::OFF_PDIV: v[3:0] = pbusDiv;
			scu_pkg::OFF_SRST: v[28:0] = slowRst;
			scu_pkg::OFF_FRST: v[3:0] = fastRst;
			scu_pkg::OFF_SGATE: v[28:0] = slowGate;
			scu_pkg::OFF_FGATE: v[3:0] = fastGate;
			scu_pkg::OFF_HALT: v[28:0] = clkHalt;
			scu_pkg::OFF_ID: v = CHIP_ID;
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	// Pin inputs: three flops, a change counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			flt <= '0;
			fltD <= '0;
		end
		else
		begin
			s1 <= {extOscStable, pllLocked, rtcAlarm, externalIrqLines, bootPinOne,
				bootPinZero, extLogicResetReq};
			s2 <= s1;
			s3 <= s2;
			flt <= (s2 & s3) | (flt & (s2 | s3));
			fltD <= flt;
		end
	end

	// Bus strobes and write merge; byte lanes without strobe keep old bits
	always_comb
	begin
		wrFire = awHeld && wHeld && !s_axi_bvalid;
		for (int i = 0; i < 4; i++)
			wMask[i*8 +: 8] = {8{wStrb[i]}};
		merged = (readWord(awAddr) & ~wMask) | (wData & wMask);
		swTrig = wrFire && awAddr == scu_pkg::OFF_RST && merged[scu_pkg::SOFTWARE_RESET_TRIGGER_BIT];
		clrTrig = wrFire && awAddr == scu_pkg::OFF_RST && merged[scu_pkg::RST_CLR_BIT];
		extTrig = flt[SY_EXT] && !fltD[SY_EXT] && extAllow;
		wakeHit = ({flt[SY_ALM], flt[SY_IRQ +: 8]} & ~{fltD[SY_ALM], fltD[SY_IRQ +: 8]}
			& riseSel) | (~{flt[SY_ALM], flt[SY_IRQ +: 8]} & {fltD[SY_ALM],
			fltD[SY_IRQ +: 8]} & fallSel);
	end

	// Boot latch: counts edges after reset, restarts on a software reset
	always_comb
	begin
		next_bootCnt = bootCnt;
		next_bootDone = bootDone;
		next_bootStatus = bootStatus;
		if (swTrig)
		begin
			next_bootCnt = 3'h0;
			next_bootDone = 1'b0;
		end
		else if (!bootDone)
		begin
			if (bootCnt == scu_pkg::BOOT_EDGE - 3'h1)
			begin
				if (s2[SY_B1:SY_B0] == s3[SY_B1:SY_B0])
				begin
					next_bootStatus = s3[SY_B1:SY_B0];
					next_bootDone = 1'b1;
				end
			end
			else
				next_bootCnt = bootCnt + 3'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bootCnt <= 3'h0;
			bootDone <= 1'b0;
			bootStatus <= 2'h0;
		end
		else
		begin
			bootCnt <= next_bootCnt;
			bootDone <= next_bootDone;
			bootStatus <= next_bootStatus;
		end
	end

	// Register writes; hardware set wins over software clear
	always_comb
	begin
		next_causeFlags = clrTrig ? 7'h0 : causeFlags;
		next_causeFlags[scu_pkg::C_LPWR] |= lowpowerResetEvt;
		next_causeFlags[scu_pkg::C_WDOG] |= sysWatchdogResetEvt;
		next_causeFlags[scu_pkg::C_INDEPENDENT_WATCHDOG] |= indepWatchdogResetEvt;
		next_causeFlags[scu_pkg::C_SFT] |= swTrig;
		next_causeFlags[scu_pkg::C_PIN] |= pinResetEvt;
		next_causeFlags[scu_pkg::C_EXT] |= extTrig;
		next_sysResetReq = swTrig || extTrig;
		next_extAllow = extAllow;
		next_lpSel = lpSel;
		next_fdiv = fdiv;
		next_oscCtl = oscCtl;
		next_pinReuse = pinReuse;
		next_dbgCtl = dbgCtl;
		next_riseSel = riseSel;
		next_fallSel = fallSel;
		next_pending = pending;
		next_pbusDiv = pbusDiv;
		next_slowRst = slowRst;
		next_fastRst = fastRst;
		next_slowGate = slowGate;
		next_fastGate = fastGate;
		next_clkHalt = clkHalt;
		if (wrFire)
		begin
			case (awAddr)
				scu_pkg::OFF_RST: next_extAllow = merged[scu_pkg::RST_EXT_BIT];
				scu_pkg::OFF_PWR: next_lpSel = merged[1:0];
				scu_pkg::OFF_CLK:
				begin
					next_fdiv = merged[scu_pkg::FDIV_LO +: 8];
					// Ready bit 4 sits between the enables, so pick the three apart
					next_oscCtl = {merged[scu_pkg::PLL_ON], merged[scu_pkg::OSC_BYP],
						merged[scu_pkg::OSC_ON]};
				end
				scu_pkg::OFF_PIN: next_pinReuse = merged[4:0];
				scu_pkg::OFF_DBG: next_dbgCtl = merged[scu_pkg::DBG_INDEPENDENT_WATCHDOG +: 2];
				scu_pkg::OFF_RISE: next_riseSel = merged[8:0];
				scu_pkg::OFF_FALL: next_fallSel = merged[8:0];
				scu_pkg::OFF_PEND: next_pending = pending & ~(wData[8:0] & wMask[8:0]);
				scu_pkg::OFF_PDIV: next_pbusDiv = merged[3:0];
				scu_pkg::OFF_SRST: next_slowRst = merged[28:0];
				scu_pkg::OFF_FRST: next_fastRst = merged[3:0];
				scu_pkg::OFF_SGATE: next_slowGate = merged[28:0];
				scu_pkg::OFF_FGATE: next_fastGate = merged[3:0];
				scu_pkg::OFF_HALT: next_clkHalt = merged[28:0];
				default: next_extAllow = extAllow;
			endcase
		end
		next_pending = next_pending | wakeHit;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			causeFlags <= scu_pkg::CAUSE_RESET;
			sysResetReq <= 1'b0;
			extAllow <= 1'b0;
			lpSel <= scu_pkg::LP_SLEEP;
			fdiv <= 8'h0;
			oscCtl <= 3'h0;
			pinReuse <= 5'h0;
			dbgCtl <= 2'h0;
			riseSel <= 9'h0;
			fallSel <= 9'h0;
			pending <= 9'h0;
			pbusDiv <= 4'h0;
			slowRst <= scu_pkg::REG_RESET[28:0];
			fastRst <= 4'h0;
			slowGate <= scu_pkg::REG_RESET[28:0];
			fastGate <= 4'h0;
			clkHalt <= scu_pkg::REG_RESET[28:0];
		end
		else
		begin
			causeFlags <= next_causeFlags;
			sysResetReq <= next_sysResetReq;
			extAllow <= next_extAllow;
			lpSel <= next_lpSel;
			fdiv <= next_fdiv;
			oscCtl <= next_oscCtl;
			pinReuse <= next_pinReuse;
			dbgCtl <= next_dbgCtl;
			riseSel <= next_riseSel;
			fallSel <= next_fallSel;
			pending <= next_pending;
			pbusDiv <= next_pbusDiv;
			slowRst <= next_slowRst;
			fastRst <= next_fastRst;
			slowGate <= next_slowGate;
			fastGate <= next_fastGate;
			clkHalt <= next_clkHalt;
		end
	end

	// Power state; standby is left only through reset
	always_comb
	begin
		next_pwrState = pwrState;
		next_wakeUp = 1'b0;
		case (pwrState)
			scu_pkg::PS_RUN:
				if (wfiReq)
				begin
					case (lpSel)
						scu_pkg::LP_STOP: next_pwrState = scu_pkg::PS_STOP;
						scu_pkg::LP_STANDBY: next_pwrState = scu_pkg::PS_STANDBY;
						default: next_pwrState = scu_pkg::PS_SLEEP;
					endcase
				end
			scu_pkg::PS_SLEEP:
				if (irqWake || |wakeHit)
					next_pwrState = scu_pkg::PS_RUN;
			scu_pkg::PS_STOP:
				if (|wakeHit)
				begin
					next_pwrState = scu_pkg::PS_RUN;
					next_wakeUp = 1'b1;
				end
			scu_pkg::PS_STANDBY: next_pwrState = scu_pkg::PS_STANDBY;
			default: next_pwrState = scu_pkg::PS_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwrState <= scu_pkg::PS_RUN;
			wakeUp <= 1'b0;
		end
		else
		begin
			pwrState <= next_pwrState;
			wakeUp <= next_wakeUp;
		end
	end

	// AXI4-Lite slave: address and data taken in either order, one at a time
	always_comb
	begin
		s_axi_awready = !awHeld;
		s_axi_wready = !wHeld;
		s_axi_arready = !s_axi_rvalid;
		next_awHeld = (awHeld || s_axi_awvalid) && !wrFire;
		next_awAddr = awHeld ? awAddr : s_axi_awaddr;
		next_wHeld = (wHeld || s_axi_wvalid) && !wrFire;
		next_wData = wHeld ? wData : s_axi_wdata;
		next_wStrb = wHeld ? wStrb : s_axi_wstrb;
		next_bvalid = wrFire || (s_axi_bvalid && !s_axi_bready);
		next_bresp = s_axi_bresp;
		if (wrFire)
			next_bresp = mapped(awAddr) ? scu_pkg::RESP_OKAY : scu_pkg::RESP_SLVERR;
		next_rvalid = s_axi_rvalid ? !s_axi_rready : s_axi_arvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && !s_axi_rvalid)
		begin
			next_rdata = readWord(s_axi_araddr);
			next_rresp = mapped(s_axi_araddr) ? scu_pkg::RESP_OKAY : scu_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awHeld <= 1'b0;
			awAddr <= 12'h000;
			wHeld <= 1'b0;
			wData <= 32'h0;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= scu_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= scu_pkg::RESP_OKAY;
		end
		else
		begin
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld <= next_wHeld;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// Clock dividers; the low divider copy is trusted to match
	scu_rate_div uFlashDiv (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.divide(fdiv[7:4]),
		.tick(flashClkTick)
	);
	scu_rate_div uPbusDiv (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.divide(pbusDiv),
		.tick(pbusClkTick)
	);

	// Control outputs straight from register flops; the two debug halts are also gated by debugActive
	assign lowPowerSelect = lpSel;
	assign sleepActive = pwrState[1];
	assign stopActive = pwrState[2];
	assign standbyActive = pwrState[3];
	assign {pllOn, extOscBypass, extOscPower} = oscCtl;
	assign debugPinReuse = pinReuse;
	assign rtcHaltInDebug = dbgCtl[1] && debugActive;
	assign indepWatchdogHaltInDebug = dbgCtl[0] && debugActive;
	assign slowBusReset = slowRst;
	assign fastBusReset = fastRst;
	// Gated enables; halt only for blocks that support it
	assign slowBusClkEn = slowGate & {scu_pkg::SLOW_N{pbusClkTick}}
		& ~(clkHalt & scu_pkg::HALT_MASK & {scu_pkg::SLOW_N{debugActive}});
	assign fastBusClkEn = fastGate;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_BOOT_LATCH: assert property (!bootDone && bootCnt == 3'h3 && s2[2:1] == s3[2:1]
		&& !swTrig |=> bootDone && bootStatus == $past(s3[2:1]))
		else $error("boot pins not latched");
	AST_BOOT_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
		|=> s_axi_rvalid && s_axi_rdata == {30'h0, $past(bootStatus)})
		else $error("boot register read wrong");
	AST_SW_CAUSE: assert property (swTrig |=> sysResetReq && causeFlags[3])
		else $error("software reset not recorded");
	AST_FLAG_CLEAR: assert property (clrTrig && !swTrig && !extTrig && !lowpowerResetEvt
		&& !sysWatchdogResetEvt && !indepWatchdogResetEvt && !pinResetEvt |=> causeFlags == 7'h0)
		else $error("cause flags not cleared");
	AST_EXT_GATE: assert property (!extAllow && !swTrig |=> !sysResetReq)
		else $error("external reset not gated");
	AST_SELF_CLEAR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h004
		|=> s_axi_rdata[24] == 1'b0 && s_axi_rdata[0] == 1'b0)
		else $error("pulse bits read as one");
	AST_STOP_ENTER: assert property (pwrState == scu_pkg::PS_RUN && wfiReq && lpSel == 2'h1
		|=> stopActive && !sleepActive)
		else $error("stop mode not entered");
	AST_WAKE_PEND: assert property (|wakeHit |=> (pending & $past(wakeHit)) == $past(wakeHit))
		else $error("wake pending bit missing");
	// Looks back over a steady divide, so a later rewrite cannot trip it
	AST_PERIPH_BUS_DIV_FIELD: assert property (pbusClkTick && pbusDiv == 4'h3 && $past(pbusDiv) == 4'h3
		&& $past(pbusDiv, 2) == 4'h3 && $past(pbusDiv, 3) == 4'h3 && $past(pbusDiv, 4) == 4'h3
		|-> $past(pbusClkTick, 4) && !$past(pbusClkTick) && !$past(pbusClkTick, 2)
		&& !$past(pbusClkTick, 3))
		else $error("peripheral bus rate wrong");
	AST_DBG_HALT: assert property (debugActive |-> (slowBusClkEn & clkHalt & 29'h041FC002) == 0)
		else $error("clock runs in debug");
	AST_GATE_RATE: assert property (|slowBusClkEn |-> pbusClkTick)
		else $error("slow clock outside divider tick");
	AST_ID_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h100
		|=> s_axi_rdata == CHIP_ID && s_axi_rresp == 2'h0)
		else $error("identifier read wrong");

	COV_SW_RESET: cover property (swTrig ##1 sysResetReq);
	COV_STOP_WAKE: cover property (stopActive ##[1:1000] wakeUp);
	COV_BAD_ADDR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// file: system_control_unit_test.sv
// Self-checking bench for the system control register bank
`timescale 1ns/1ps
module system_control_unit_test;
	// Arbitrary identification value
	localparam logic [31:0] ID = 32'h0BADF00D;
	logic sys_clk = 1'b0, rst_n = 1'b0;
	logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic [31:0] wData = 32'h00000000, seed = 32'h000033E6;
	logic awReady, wReady, bValid, rValid, arReady, sysRst, wakeUp, sleepA, stopA, standbyA;
	logic [1:0] bResp, rResp, lpSel;
	logic [31:0] rData;
	logic boot_pin_zero = 1'b0, boot_pin_one = 1'b0, extReq = 1'b0, wfi = 1'b0, irqWk = 1'b0, dbg = 1'b0;
	logic alarm = 1'b0, pllLk = 1'b1, oscSt = 1'b0;
	logic [3:0] evt = 4'h0; // Low power, system wd, indep wd, pin
	logic [7:0] irqs = 8'h00;
	logic [3:0] strb = 4'hF;
	logic pllOn, oscPwr, oscByp, fTick, pTick, rtcH, iwdH;
	logic [4:0] pinReuse;
	logic [28:0] sRst, sEn;
	logic [3:0] fRst, fEn;
	int error_cnt = 0, tests_run = 0, rstCnt = 0, wakeCnt = 0, fCnt = 0, pCnt = 0;
	logic [11:0] addrs [8] = '{scu_pkg::OFF_PIN, scu_pkg::OFF_PWR, scu_pkg::OFF_DBG,
		scu_pkg::OFF_PDIV, scu_pkg::OFF_SRST, scu_pkg::OFF_FRST, scu_pkg::OFF_SGATE,
		scu_pkg::OFF_FGATE};
	logic [31:0] masks [8] = '{32'h1F, 32'h3, 32'h18, 32'hF, 32'h1FFFFFFF, 32'hF,
		32'h1FFFFFFF, 32'hF};

	scu_system_control #(.CHIP_ID(ID)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(strb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.bootPinZero(boot_pin_zero), .bootPinOne(boot_pin_one), .extLogicResetReq(extReq),
		.lowpowerResetEvt(evt[3]), .sysWatchdogResetEvt(evt[2]), .indepWatchdogResetEvt(evt[1]),
		.pinResetEvt(evt[0]), .wfiReq(wfi), .irqWake(irqWk), .debugActive(dbg),
		.externalIrqLines(irqs), .rtcAlarm(alarm), .pllLocked(pllLk), .extOscStable(oscSt),
		.sysResetReq(sysRst), .lowPowerSelect(lpSel), .sleepActive(sleepA), .stopActive(stopA),
		.standbyActive(standbyA), .wakeUp(wakeUp), .pllOn(pllOn), .extOscPower(oscPwr),
		.extOscBypass(oscByp), .flashClkTick(fTick), .pbusClkTick(pTick),
		.debugPinReuse(pinReuse), .rtcHaltInDebug(rtcH), .indepWatchdogHaltInDebug(iwdH),
		.slowBusReset(sRst), .fastBusReset(fRst), .slowBusClkEn(sEn), .fastBusClkEn(fEn));

	initial
	begin
		forever #20 sys_clk = ~sys_clk;
	end

	// Count pulses mid-cycle, where they have settled
	always @(negedge sys_clk)
	begin
		rstCnt <= rstCnt + int'(sysRst === 1'b1);
		wakeCnt <= wakeCnt + int'(wakeUp === 1'b1);
		fCnt <= fCnt + int'(fTick === 1'b1);
		pCnt <= pCnt + int'(pTick === 1'b1);
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] portOf(int k, logic [31:0] e);
		case (k)
			0: return {27'h0, pinReuse};
			1: return {30'h0, lpSel};
			4: return {3'h0, sRst};
			5: return {28'h0, fRst};
			7: return {28'h0, fEn};
			default: return e;
		endcase
	endfunction

	task automatic give_verdict();
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Handshakes judged at the falling edge, so the next rising edge is known
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		@(posedge sys_clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		tb = 1'b0;
		for (n = 0; n < 50 && !tb; n++)
		begin
			@(negedge sys_clk);
			ta = awValid && awReady;
			tw = wValid && wReady;
			tb = bValid;
			if (tb)
				chk({30'h0, bResp}, {30'h0, er});
			@(posedge sys_clk);
			if (ta) awValid <= 1'b0;
			if (tw) wValid <= 1'b0;
			if (tb) bReady <= 1'b0;
		end
		if (!tb)
		begin
			error_cnt++;
			give_verdict();
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		logic ta, tr;
		@(posedge sys_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		tr = 1'b0;
		for (n = 0; n < 50 && !tr; n++)
		begin
			@(negedge sys_clk);
			ta = arValid && arReady;
			tr = rValid;
			d = rData;
			if (tr)
				chk({30'h0, rResp}, {30'h0, er});
			@(posedge sys_clk);
			if (ta) arValid <= 1'b0;
			if (tr) rReady <= 1'b0;
		end
		if (!tr)
		begin
			error_cnt++;
			give_verdict();
		end
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, scu_pkg::RESP_OKAY, d);
		chk(d, e);
	endtask

	// Reset with fresh boot pins, then expect them latched
	task automatic doReset();
		logic [31:0] v;
		v = rnd();
		@(posedge sys_clk);
		boot_pin_zero <= v[0];
		boot_pin_one <= v[1];
		rst_n <= 1'b0;
		cyc(5);
		rst_n <= 1'b1;
		cyc(8);
		rc(scu_pkg::OFF_BOOT, {30'h0, v[1:0]}); // Boot pins
		rc(scu_pkg::OFF_RST, 32'h08000000); // Power-on flag
	endtask

	task automatic lpEnter(input logic [1:0] c, input logic [2:0] e);
		wr(scu_pkg::OFF_PWR, {30'h0, c}, scu_pkg::RESP_OKAY);
		wfi <= 1'b1;
		@(posedge sys_clk);
		wfi <= 1'b0;
		cyc(2);
		chk({29'h0, sleepA, stopA, standbyA}, {29'h0, e}); // Mode entered
	endtask

	// Hang guard
	initial
	begin
		#4000000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		logic [31:0] v, d;
		int i, k, m, p;
		doReset();
		rc(scu_pkg::OFF_ID, ID); // Identifier
		wr(scu_pkg::OFF_RST, 32'h01000000, scu_pkg::RESP_OKAY); // Clear flags
		rc(scu_pkg::OFF_RST, 32'h0); // Clear bit reads zero
		evt <= 4'hF;
		@(posedge sys_clk);
		evt <= 4'h0;
		rc(scu_pkg::OFF_RST, 32'hE4000000); // Event flags
		wr(scu_pkg::OFF_RST, 32'h01000002, scu_pkg::RESP_OKAY); // Allow external
		m = rstCnt;
		extReq <= 1'b1;
		cyc(12);
		chk(32'(rstCnt - m), 32'h1); // Honoured request
		rc(scu_pkg::OFF_RST, 32'h02000002); // External flag
		extReq <= 1'b0;
		wr(scu_pkg::OFF_RST, 32'h01000000, scu_pkg::RESP_OKAY);
		extReq <= 1'b1;
		cyc(12);
		chk(32'(rstCnt - m), 32'h1); // Ignored request
		extReq <= 1'b0;
		wr(scu_pkg::OFF_RST, 32'h00000001, scu_pkg::RESP_OKAY);
		cyc(4);
		chk(32'(rstCnt - m), 32'h2); // Software request
		rc(scu_pkg::OFF_RST, 32'h10000000); // Trigger reads zero
		// All-ones corners first, then random values
		for (i = 0; i < 16; i++)
		begin
			k = i % 8;
			v = (i < 8) ? masks[k] : (rnd() & masks[k]);
			wr(addrs[k], v, scu_pkg::RESP_OKAY);
			rc(addrs[k], v);
			chk(portOf(k, v), v); // Outputs
		end
		// Only the low byte lane is written
		wr(scu_pkg::OFF_SRST, 32'h1FFFFFFF, scu_pkg::RESP_OKAY);
		strb <= 4'h1;
		wr(scu_pkg::OFF_SRST, 32'h0, scu_pkg::RESP_OKAY);
		strb <= 4'hF;
		rc(scu_pkg::OFF_SRST, 32'h1FFFFF00); // Lane merge
		for (i = 0; i < 4; i++)
		begin
			d = (i == 0) ? 32'h0 : (i == 1) ? 32'hF : (i == 2) ? 32'h3 : (rnd() & 32'hF);
			oscSt <= d[0];
			pllLk <= d[1];
			wr(scu_pkg::OFF_CLK, (d << 12) | (d << 8) | 32'h24 | {d[2], 3'h0},
				scu_pkg::RESP_OKAY); // Equal divider fields
			wr(scu_pkg::OFF_PDIV, d, scu_pkg::RESP_OKAY);
			cyc(6);
			rc(scu_pkg::OFF_CLK, (d << 12) | (d << 8) | 32'h24
				| {d[1], 1'b0, d[0], d[2], 3'h0}); // Clock bits
			chk({29'h0, pllOn, oscByp, oscPwr}, {29'h0, 1'b1, d[2], 1'b1}); // Enables
			m = fCnt;
			p = pCnt;
			repeat (8 * (d + 1)) @(posedge sys_clk);
			chk(32'(fCnt - m), 32'h8); // Flash rate
			chk(32'(pCnt - p), 32'h8); // Bus rate
		end
		wr(scu_pkg::OFF_DBG, 32'h18, scu_pkg::RESP_OKAY);
		wr(scu_pkg::OFF_SGATE, 32'h1FFFFFFF, scu_pkg::RESP_OKAY);
		wr(scu_pkg::OFF_HALT, 32'h1FFFFFFF, scu_pkg::RESP_OKAY);
		wr(scu_pkg::OFF_PDIV, 32'h0, scu_pkg::RESP_OKAY);
		dbg <= 1'b1;
		cyc(2);
		chk({30'h0, rtcH, iwdH}, 32'h3); // Halts in debug
		chk({3'h0, sEn}, {3'h0, ~scu_pkg::HALT_MASK}); // Stopped clocks
		dbg <= 1'b0;
		cyc(2);
		chk({3'h0, sEn}, 32'h1FFFFFFF); // Enabled clocks
		lpEnter(scu_pkg::LP_SLEEP, 3'b100); // Sleep
		irqWk <= 1'b1;
		@(posedge sys_clk);
		irqWk <= 1'b0;
		cyc(2);
		chk({31'h0, sleepA}, 32'h0); // Left sleep
		k = int'(rnd() & 32'h7);
		wr(scu_pkg::OFF_RISE, 32'h1 << k, scu_pkg::RESP_OKAY);
		wr(scu_pkg::OFF_FALL, 32'h100, scu_pkg::RESP_OKAY);
		wr(scu_pkg::OFF_PEND, 32'h1FF, scu_pkg::RESP_OKAY);
		lpEnter(scu_pkg::LP_STOP, 3'b010); // Stop
		m = wakeCnt;
		irqs[k] <= 1'b1;
		for (i = 0; i < 20 && wakeCnt == m; i++)
			@(posedge sys_clk);
		cyc(2);
		chk(32'(wakeCnt - m), 32'h1); // Line wakes
		chk({31'h0, stopA}, 32'h0); // Left stop
		rc(scu_pkg::OFF_PEND, 32'h1 << k); // Pending line
		irqs[k] <= 1'b0;
		cyc(8);
		wr(scu_pkg::OFF_PEND, 32'h1FF, scu_pkg::RESP_OKAY);
		rc(scu_pkg::OFF_PEND, 32'h0); // Pending cleared by write
		alarm <= 1'b1;
		cyc(8);
		rc(scu_pkg::OFF_PEND, 32'h0); // Alarm rise unselected
		alarm <= 1'b0;
		cyc(8);
		rc(scu_pkg::OFF_PEND, 32'h100); // Alarm fall
		wr(12'h0FC, rnd(), scu_pkg::RESP_SLVERR);
		rd(12'h0FC, scu_pkg::RESP_SLVERR, d);
		chk(d, 32'h0);
		lpEnter(scu_pkg::LP_STANDBY, 3'b001); // Standby
		doReset(); // Second latch
		give_verdict();
	end
endmodule
